/* logic/cpu_operand_address_generator.sv */
// operand address generator: fetches operand and pointer bytes, forms the ea
// assumes the core presents one instruction at a time with its opcode address
//
// Behaviour
// RULE1: seventeen addressing modes in seven groups
// RULE2: short forms page zero, long forms 64K
// RULE3: read-modify-write only with short addressing
// RULE4: inherent is one byte, no operand fetch
// RULE5: immediate is opcode plus operand byte
// RULE6: short direct takes one page-zero address byte
// RULE7: long direct takes a two-byte address
// RULE8: indexed address is unsigned index plus offset
// RULE9: no-offset indexed uses index alone
// RULE10: short indexed offset byte, up to 1FE
// RULE11: long indexed word offset plus index
// RULE12: indirect byte addresses a pointer in memory
// RULE13: short indirect reads one-byte page-zero pointer
// RULE14: long indirect reads two-byte page-zero pointer
// RULE15: set mask gives level 3, clear gives 0
// RULE16: wait idles until interrupt; halt stops oscillator
// RULE17: short indirect indexed: byte pointer plus index
// RULE18: relative adds signed 8-bit displacement to pc
// RULE19: words msb first; short sums never wrap
// RULE20: report full length so pc skips operands
`timescale 1ns/1ps
module cpu_operand_address_generator
   import opaddr_pkg::*;
(
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // instruction request
   input  wire logic         start_i,
   input  wire mode_t        mode_i,
   input  wire logic         use_y_i,
   input  wire logic         rmw_i,
   input  wire inh_op_t      inh_op_i,
   input  wire logic [15:0]  pc_i,
   input  wire logic [7:0]   idx_x_i,
   input  wire logic [7:0]   idx_y_i,
   output logic              ready_o,
   // result
   output logic              done_o,
   output logic              illegal_o,
   output logic [15:0]       ea_o,
   output logic [7:0]        imm_o,
   output logic [15:0]       target_o,
   output logic [15:0]       next_pc_o,
   output logic [2:0]        length_o,
   // memory bus
   output logic              mem_req_o,
   output logic [15:0]       mem_addr_o,
   input  wire logic         mem_ack_i,
   input  wire logic [7:0]   mem_rdata_i,
   // core control
   input  wire logic         irq_i,
   output logic [1:0]        irq_level_o,
   output logic              wait_o,
   output logic              halt_o
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_OPND = 4'b0010,
      ST_PTR  = 4'b0100,
      ST_DONE = 4'b1000
   } state_t;

   state_t      state_r;
   mode_t       mode_r;
   logic        use_y_r;
   logic        bad_r;
   logic [15:0] pc_r;
   logic [7:0]  idx_r;
   logic [1:0]  cnt_r;
   logic [7:0]  b0_r;
   logic [7:0]  b1_r;
   logic [7:0]  p0_r;
   logic [7:0]  p1_r;
   logic        done_r;
   logic        illegal_r;
   logic [15:0] ea_r;
   logic [7:0]  imm_r;
   logic [15:0] target_r;
   logic [15:0] next_pc_r;
   logic [2:0]  length_r;
   logic [1:0]  irq_level_r;
   logic        wait_r;
   logic        halt_r;

   logic [1:0]  opnd_bytes;
   logic [1:0]  ptr_bytes;
   logic        prebyte;
   logic        long_mode;
   logic        mode_ok;
   logic [1:0]  in_opnd;
   logic [1:0]  in_ptr;
   logic        in_pre;
   logic        in_long;
   logic        in_ok;
   logic [15:0] ea_w;
   logic [15:0] target_w;
   logic [15:0] next_pc_w;
   logic [2:0]  length_w;
   logic        take;
   logic        refuse;

   // latched mode drives the byte counts during the fetch
   mode_decode u_dec_r (
      .mode_i       (mode_r),
      .use_y_i      (use_y_r),
      .opnd_bytes_o (opnd_bytes),
      .ptr_bytes_o  (ptr_bytes),
      .prebyte_o    (prebyte),
      .long_o       (long_mode),
      .valid_o      (mode_ok)
   );

   // incoming mode decides the first state and the rmw check
   mode_decode u_dec_i (
      .mode_i       (mode_i),
      .use_y_i      (use_y_i),
      .opnd_bytes_o (in_opnd),
      .ptr_bytes_o  (in_ptr),
      .prebyte_o    (in_pre),
      .long_o       (in_long),
      .valid_o      (in_ok)
   );

   ea_calc u_ea (
      .mode_i    (mode_r),
      .b0_i      (b0_r),
      .b1_i      (b1_r),
      .p0_i      (p0_r),
      .p1_i      (p1_r),
      .idx_i     (idx_r),
      .next_pc_i (next_pc_w),
      .ea_o      (ea_w),
      .target_o  (target_w)
   );

   assign ready_o = (state_r == ST_IDLE);
   assign take    = start_i && ready_o;
   // long forms and immediate data cannot be written back
   assign refuse  = !in_ok || (rmw_i && (in_long || mode_i == MODE_IMM));   // RULE3

   // next opcode sits after every operand byte; prebyte lies before pc
   assign next_pc_w = pc_r + 16'h0001 + {14'h0000, opnd_bytes};             // RULE20
   assign length_w  = 3'h1 + {2'h0, prebyte} + {1'b0, opnd_bytes};          // RULE20

   // fetch sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 2'h0;
      end else begin
         unique case (state_r)
            ST_IDLE : begin
               cnt_r <= 2'h0;
               if (take) begin
                  if (refuse || in_opnd == 2'h0) begin
                     state_r <= ST_DONE;                                    // RULE4 RULE9
                  end else begin
                     state_r <= ST_OPND;
                  end
               end
            end
            ST_OPND : begin
               if (mem_ack_i) begin
                  if (cnt_r == opnd_bytes - 2'h1) begin
                     cnt_r   <= 2'h0;
                     state_r <= (ptr_bytes != 2'h0) ? ST_PTR : ST_DONE;     // RULE12
                  end else begin
                     cnt_r <= cnt_r + 2'h1;
                  end
               end
            end
            ST_PTR : begin
               if (mem_ack_i) begin
                  if (cnt_r == ptr_bytes - 2'h1) begin
                     cnt_r   <= 2'h0;
                     state_r <= ST_DONE;
                  end else begin
                     cnt_r <= cnt_r + 2'h1;
                  end
               end
            end
            ST_DONE : state_r <= ST_IDLE;
         endcase
      end
   end

   // request capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r  <= MODE_INH;
         use_y_r <= 1'b0;
         bad_r   <= 1'b0;
         pc_r    <= ADDR_RESET;
         idx_r   <= BYTE_RESET;
      end else if (take) begin
         mode_r  <= refuse ? MODE_INH : mode_i;
         use_y_r <= use_y_i;
         bad_r   <= refuse;                                                 // RULE3
         pc_r    <= pc_i;
         idx_r   <= use_y_i ? idx_y_i : idx_x_i;                            // RULE8
      end
   end

   // gathered bytes, first byte is the high one of a word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b0_r <= BYTE_RESET;
         b1_r <= BYTE_RESET;
         p0_r <= BYTE_RESET;
         p1_r <= BYTE_RESET;
      end else if (mem_ack_i && state_r == ST_OPND) begin
         if (cnt_r == 2'h0) begin
            b0_r <= mem_rdata_i;                                            // RULE19
         end else begin
            b1_r <= mem_rdata_i;
         end
      end else if (mem_ack_i && state_r == ST_PTR) begin
         if (cnt_r == 2'h0) begin
            p0_r <= mem_rdata_i;                                            // RULE19
         end else begin
            p1_r <= mem_rdata_i;
         end
      end
   end

   // operand bytes follow the opcode; pointers live in page zero
   always_comb begin
      mem_req_o  = (state_r == ST_OPND) || (state_r == ST_PTR);
      mem_addr_o = pc_r + 16'h0001 + {14'h0000, cnt_r};
      if (state_r == ST_PTR) begin
         mem_addr_o = {PAGE_ZERO_HI, b0_r + {6'h00, cnt_r}};                // RULE13 RULE14
      end
   end

   // results, registered when the last byte is in
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r    <= 1'b0;
         illegal_r <= 1'b0;
         ea_r      <= ADDR_RESET;
         imm_r     <= BYTE_RESET;
         target_r  <= ADDR_RESET;
         next_pc_r <= ADDR_RESET;
         length_r  <= LEN_RESET;
      end else begin
         done_r <= (state_r == ST_DONE);
         if (state_r == ST_DONE) begin
            illegal_r <= bad_r || !mode_ok;
            ea_r      <= ea_w;                                              // RULE2
            imm_r     <= (mode_r == MODE_IMM) ? b0_r : BYTE_RESET;          // RULE5
            target_r  <= target_w;                                          // RULE18
            next_pc_r <= next_pc_w;
            length_r  <= length_w;
         end
      end
   end

   // inherent side effects; interrupt wakes both low-power states
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_level_r <= IRQ_LEVEL_RST;
         wait_r      <= 1'b0;
         halt_r      <= 1'b0;
      end else begin
         if (take && mode_i == MODE_INH) begin
            if (inh_op_i == SET_IRQ_MASK_OP) begin
               irq_level_r <= IRQ_LEVEL_SET;                                // RULE15
            end else if (inh_op_i == CLEAR_IRQ_MASK_OP) begin
               irq_level_r <= IRQ_LEVEL_CLEAR;                              // RULE15
            end
         end
         if (irq_i) begin
            wait_r <= 1'b0;                                                 // RULE16
            halt_r <= 1'b0;
         end else if (take && mode_i == MODE_INH) begin
            if (inh_op_i == WAIT_IRQ_OP) begin
               wait_r <= 1'b1;                                              // RULE16
            end else if (inh_op_i == HALT_OP) begin
               halt_r <= 1'b1;                                              // RULE16
            end
         end
      end
   end

   assign done_o      = done_r;
   assign illegal_o   = illegal_r;
   assign ea_o        = ea_r;
   assign imm_o       = imm_r;
   assign target_o    = target_r;
   assign next_pc_o   = next_pc_r;
   assign length_o    = length_r;
   assign irq_level_o = irq_level_r;
   assign wait_o      = wait_r;
   assign halt_o      = halt_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_inherent_one_byte: assert property (                                  // RULE4
      take && mode_i == MODE_INH && !rmw_i |-> !mem_req_o ##1 !mem_req_o
         ##1 (done_o && length_o == 3'h1))
      else $error("inherent op fetched bytes or wrong length");

   a_immediate_len: assert property (                                      // RULE5
      done_o && mode_r == MODE_IMM && !illegal_o |-> length_o == 3'h2 && imm_o == b0_r)
      else $error("immediate length or value wrong");

   a_rmw_long_refused: assert property (                                   // RULE3
      take && rmw_i && (mode_i == MODE_DIR_L || mode_i == MODE_IDX_L)
         |-> ##2 (done_o && illegal_o))
      else $error("long rmw not refused");

   a_short_direct_page: assert property (                                  // RULE6
      done_o && mode_r == MODE_DIR_S |-> ea_o == {PAGE_ZERO_HI, b0_r})
      else $error("short direct left page zero");

   a_long_msb_first: assert property (                                     // RULE7
      done_o && mode_r == MODE_DIR_L |-> ea_o == {b0_r, b1_r} && length_o == 3'h3)
      else $error("long direct word order wrong");

   a_idx_short_sum: assert property (                                      // RULE10
      done_o && mode_r == MODE_IDX_S |-> ea_o <= SHORT_IDX_MAX
         && ea_o == {8'h00, b0_r} + {8'h00, idx_r})
      else $error("short indexed sum wrong");

   a_ptr_page_zero: assert property (                                      // RULE13
      state_r == ST_PTR |-> mem_req_o && mem_addr_o[15:8] == PAGE_ZERO_HI)
      else $error("pointer read outside page zero");

   a_long_ind_word: assert property (                                      // RULE14
      done_o && mode_r == MODE_IND_L |-> ea_o == {p0_r, p1_r} && length_o == 3'h3)
      else $error("long indirect pointer wrong");

   a_mask_levels: assert property (                                        // RULE15
      take && mode_i == MODE_INH && inh_op_i == SET_IRQ_MASK_OP
         |=> irq_level_o == IRQ_LEVEL_SET)
      else $error("set mask did not reach level 3");

   a_mask_clear: assert property (                                         // RULE15
      take && mode_i == MODE_INH && inh_op_i == CLEAR_IRQ_MASK_OP
         |=> irq_level_o == IRQ_LEVEL_CLEAR)
      else $error("clear mask did not reach level 0");

   a_wait_holds: assert property (                                         // RULE16
      wait_o && !irq_i |=> wait_o)
      else $error("wait left without interrupt");

   a_rel_target: assert property (                                         // RULE18
      done_o && mode_r == MODE_REL_D |-> target_o == next_pc_o + {{8{b0_r[7]}}, b0_r})
      else $error("relative target wrong");

   a_next_pc: assert property (                                            // RULE20
      done_o |-> next_pc_o == pc_r + 16'h0001 + {14'h0000, opnd_bytes})
      else $error("next pc does not skip operands");

   c_long_indirect: cover property (done_o && mode_r == MODE_INDX_L);
   c_btj_indirect:  cover property (done_o && mode_r == MODE_BTJ_I);
   c_rmw_refused:   cover property (done_o && illegal_o);
   c_wait_wake:     cover property (wait_o ##1 !wait_o);

endmodule // cpu_operand_address_generator

/* logic/opaddr_pkg.sv */
// constants shared by the operand address generator and its helpers
// assumes an 8-bit core with a 16-bit byte address space, msb-first words
package opaddr_pkg;

   // addressing modes, one code each (seventeen in all)
   typedef logic [4:0] mode_t;
   localparam mode_t MODE_INH    = 5'h00;
   localparam mode_t MODE_IMM    = 5'h01;
   localparam mode_t MODE_DIR_S  = 5'h02;
   localparam mode_t MODE_DIR_L  = 5'h03;
   localparam mode_t MODE_IDX_0  = 5'h04;
   localparam mode_t MODE_IDX_S  = 5'h05;
   localparam mode_t MODE_IDX_L  = 5'h06;
   localparam mode_t MODE_IND_S  = 5'h07;
   localparam mode_t MODE_IND_L  = 5'h08;
   localparam mode_t MODE_INDX_S = 5'h09;
   localparam mode_t MODE_INDX_L = 5'h0A;
   localparam mode_t MODE_REL_D  = 5'h0B;
   localparam mode_t MODE_REL_I  = 5'h0C;
   localparam mode_t MODE_BIT_D  = 5'h0D;
   localparam mode_t MODE_BIT_I  = 5'h0E;
   localparam mode_t MODE_BTJ_D  = 5'h0F;
   localparam mode_t MODE_BTJ_I  = 5'h10;
   localparam mode_t MODE_COUNT  = 5'h11;

   // inherent operation codes; all but OP_OTHER have side effects in this block
   typedef logic [2:0] inh_op_t;
   localparam inh_op_t OP_OTHER         = 3'h0;
   localparam inh_op_t SET_IRQ_MASK_OP  = 3'h1;
   localparam inh_op_t CLEAR_IRQ_MASK_OP = 3'h2;
   localparam inh_op_t WAIT_IRQ_OP      = 3'h3;
   localparam inh_op_t HALT_OP          = 3'h4;

   // interrupt mask levels
   localparam logic [1:0] IRQ_LEVEL_SET   = 2'h3;
   localparam logic [1:0] IRQ_LEVEL_CLEAR = 2'h0;
   localparam logic [1:0] IRQ_LEVEL_RST   = 2'h3;

   // address ranges
   localparam logic [7:0]  PAGE_ZERO_HI  = 8'h00;
   localparam logic [15:0] SHORT_IDX_MAX = 16'h01FE;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [2:0]  LEN_RESET     = 3'h0;

endpackage : opaddr_pkg

/* logic/mode_decode.sv */
// per-mode byte counts: operand bytes after the opcode and pointer size
// assumes mode_i is held stable while it is being read
`timescale 1ns/1ps
module mode_decode
   import opaddr_pkg::*;
(
   // mode in
   input  wire mode_t      mode_i,
   input  wire logic       use_y_i,
   // counts out
   output logic [1:0]      opnd_bytes_o,
   output logic [1:0]      ptr_bytes_o,
   output logic            prebyte_o,
   output logic            long_o,
   output logic            valid_o
);

   always_comb begin
      opnd_bytes_o = 2'h0;
      ptr_bytes_o  = 2'h0;
      long_o       = 1'b0;
      unique case (mode_i)
         MODE_INH, MODE_IDX_0 : opnd_bytes_o = 2'h0;                 // RULE4 RULE9
         MODE_IMM, MODE_DIR_S, MODE_IDX_S, MODE_REL_D, MODE_BIT_D :
            opnd_bytes_o = 2'h1;                                      // RULE5 RULE6 RULE10
         MODE_DIR_L, MODE_IDX_L : begin
            opnd_bytes_o = 2'h2;                                      // RULE7 RULE11
            long_o       = 1'b1;                                      // RULE2
         end
         MODE_IND_S, MODE_INDX_S, MODE_REL_I, MODE_BIT_I : begin
            opnd_bytes_o = 2'h1;                                      // RULE12 RULE13
            ptr_bytes_o  = 2'h1;
         end
         MODE_IND_L, MODE_INDX_L : begin
            opnd_bytes_o = 2'h1;                                      // RULE14
            ptr_bytes_o  = 2'h2;
            long_o       = 1'b1;
         end
         MODE_BTJ_D : opnd_bytes_o = 2'h2;
         MODE_BTJ_I : begin
            opnd_bytes_o = 2'h2;
            ptr_bytes_o  = 2'h1;
         end
         default : opnd_bytes_o = 2'h0;
      endcase
   end

   // y indexing of the plain indexed forms costs a prebyte; indirect forms always carry one
   assign prebyte_o = (ptr_bytes_o != 2'h0) ||
                      (use_y_i && (mode_i == MODE_IDX_0 || mode_i == MODE_IDX_S ||
                                   mode_i == MODE_IDX_L));
   assign valid_o   = (mode_i < MODE_COUNT);                         // RULE1

endmodule // mode_decode

/* logic/ea_calc.sv */
// effective address and relative target from gathered bytes
// assumes words arrive msb first: b0/p0 high byte, b1/p1 low byte
`timescale 1ns/1ps
module ea_calc
   import opaddr_pkg::*;
(
   // sources
   input  wire mode_t        mode_i,
   input  wire logic [7:0]   b0_i,
   input  wire logic [7:0]   b1_i,
   input  wire logic [7:0]   p0_i,
   input  wire logic [7:0]   p1_i,
   input  wire logic [7:0]   idx_i,
   input  wire logic [15:0]  next_pc_i,
   // results
   output logic [15:0]       ea_o,
   output logic [15:0]       target_o
);

   logic [7:0] disp;

   // short index sums kept at nine bits so they reach 1FE without wrapping
   function automatic logic [15:0] short_sum(input logic [7:0] a, input logic [7:0] x);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, x};
      return {7'h00, s};
   endfunction

   always_comb begin
      ea_o = ADDR_RESET;
      disp = BYTE_RESET;
      unique case (mode_i)
         MODE_DIR_S, MODE_BIT_D : ea_o = {PAGE_ZERO_HI, b0_i};           // RULE6
         MODE_BTJ_D  : begin
            ea_o = {PAGE_ZERO_HI, b0_i};
            disp = b1_i;
         end
         MODE_DIR_L  : ea_o = {b0_i, b1_i};                              // RULE7 RULE19
         MODE_IDX_0  : ea_o = {PAGE_ZERO_HI, idx_i};                     // RULE9
         MODE_IDX_S  : ea_o = short_sum(b0_i, idx_i);                    // RULE10 RULE8
         MODE_IDX_L  : ea_o = {b0_i, b1_i} + {8'h00, idx_i};             // RULE11
         MODE_IND_S, MODE_BIT_I : ea_o = {PAGE_ZERO_HI, p0_i};           // RULE13
         MODE_BTJ_I  : begin
            ea_o = {PAGE_ZERO_HI, p0_i};
            disp = b1_i;
         end
         MODE_IND_L  : ea_o = {p0_i, p1_i};                              // RULE14 RULE19
         MODE_INDX_S : ea_o = short_sum(p0_i, idx_i);                    // RULE17
         MODE_INDX_L : ea_o = {p0_i, p1_i} + {8'h00, idx_i};
         MODE_REL_D  : disp = b0_i;
         MODE_REL_I  : disp = p0_i;
         default     : ea_o = ADDR_RESET;
      endcase
   end

   assign target_o = next_pc_i + {{8{disp[7]}}, disp};                  // RULE18

endmodule // ea_calc

/* sim/mem_model.sv */
// memory bus partner: answers byte reads with an address-derived pattern
// assumes each request holds its address until acked
`timescale 1ns/1ps
module mem_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // behaviour
   input  wire logic        slow_i,
   // memory bus
   input  wire logic        mem_req_i,
   input  wire logic [15:0] mem_addr_i,
   output logic             mem_ack_o,
   output logic [7:0]       mem_rdata_o
);
   logic       ph_r;
   logic [7:0] last_r;

   // slow mode acks every other requested cycle
   assign mem_ack_o   = mem_req_i & (~slow_i | ph_r);
   // idle bus shows the inverse of the last byte, never a stale copy
   assign mem_rdata_o = mem_ack_o ? (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'hA5) : ~last_r;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         ph_r <= 1'b0;
      else if (mem_req_i)
         ph_r <= ~ph_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         last_r <= 8'h00;
      else if (mem_ack_o)
         last_r <= mem_rdata_o;
   end
endmodule // mem_model

/* sim/testbench.sv */
// self-checking bench for the operand address generator
// assumes the memory partner returns addr_lo ^ addr_hi ^ A5 for every byte
`timescale 1ns/1ps
module testbench;
   import opaddr_pkg::*;
   logic        clk_i, rst_i, start_i, use_y_i, rmw_i, irq_i, slow;
   mode_t       mode_i;
   inh_op_t     inh_op_i;
   logic [15:0] pc_i, ea_o, target_o, next_pc_o, mem_addr_o;
   logic [7:0]  idx_x_i, idx_y_i, imm_o, mem_rdata_i;
   logic [2:0]  length_o;
   logic [1:0]  irq_level_o;
   logic        ready_o, done_o, illegal_o, mem_req_o, mem_ack_i, wait_o, halt_o;
   int          n_fail, checks;

   cpu_operand_address_generator u_dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
      .mode_i(mode_i), .use_y_i(use_y_i), .rmw_i(rmw_i), .inh_op_i(inh_op_i), .pc_i(pc_i),
      .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .ready_o(ready_o), .done_o(done_o),
      .illegal_o(illegal_o), .ea_o(ea_o), .imm_o(imm_o), .target_o(target_o),
      .next_pc_o(next_pc_o), .length_o(length_o), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
      .irq_i(irq_i), .irq_level_o(irq_level_o), .wait_o(wait_o), .halt_o(halt_o));

   mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_req_i(mem_req_o),
      .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

   function automatic logic [7:0] mv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("fails %0d checks %0d", n_fail, checks);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one request, then a bounded wait for the done pulse
   task automatic go(input mode_t m, input logic y, input logic r, input inh_op_t op,
                     input logic [15:0] pc, input logic [7:0] x, input logic [7:0] yv);
      int n;
      @(posedge clk_i);
      start_i  <= 1'b1;
      mode_i   <= m;
      use_y_i  <= y;
      rmw_i    <= r;
      inh_op_i <= op;
      pc_i     <= pc;
      idx_x_i  <= x;
      idx_y_i  <= yv;
      @(posedge clk_i);
      start_i <= 1'b0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (done_o === 1'b1)
            break;
         @(posedge clk_i);
      end
      chk("done", 16'h0001, {15'h0000, done_o});
      chk("ready", 16'h0001, {15'h0000, ready_o});
   endtask

   task automatic chk_len(input logic [2:0] len, input logic [15:0] npc);
      chk("length", {13'h0000, len}, {13'h0000, length_o});
      chk("next_pc", npc, next_pc_o);
   endtask

   task automatic t_inherent;
      go(MODE_INH, 1'b0, 1'b0, OP_OTHER, 16'h1234, 8'h00, 8'h00);
      chk_len(3'h1, 16'h1235);
      go(MODE_INH, 1'b0, 1'b0, CLEAR_IRQ_MASK_OP, 16'h1235, 8'h00, 8'h00);
      chk("level", 16'h0000, {14'h0000, irq_level_o});
      go(MODE_INH, 1'b0, 1'b0, SET_IRQ_MASK_OP, 16'h1236, 8'h00, 8'h00);
      chk("level", 16'h0003, {14'h0000, irq_level_o});
      go(MODE_INH, 1'b0, 1'b0, WAIT_IRQ_OP, 16'h1237, 8'h00, 8'h00);
      chk("wait", 16'h0001, {15'h0000, wait_o});
      go(MODE_INH, 1'b0, 1'b0, HALT_OP, 16'h1238, 8'h00, 8'h00);
      chk("halt", 16'h0001, {15'h0000, halt_o});
      @(posedge clk_i);
      irq_i <= 1'b1;
      @(posedge clk_i);
      irq_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("wake", 16'h0000, {14'h0000, wait_o, halt_o});
   endtask

   task automatic t_imm_dir;
      go(MODE_IMM, 1'b0, 1'b0, OP_OTHER, 16'h2000, 8'h00, 8'h00);
      chk("imm", {8'h00, mv(16'h2001)}, {8'h00, imm_o});
      chk_len(3'h2, 16'h2002);
      slow <= 1'b1;
      go(MODE_DIR_S, 1'b0, 1'b0, OP_OTHER, 16'h0059, 8'h00, 8'h00);
      chk("ea", 16'h00FF, ea_o);
      chk_len(3'h2, 16'h005B);
      go(MODE_DIR_L, 1'b0, 1'b0, OP_OTHER, 16'h3000, 8'h00, 8'h00);
      chk("ea", {mv(16'h3001), mv(16'h3002)}, ea_o);
      chk_len(3'h3, 16'h3003);
      go(MODE_BTJ_D, 1'b0, 1'b0, OP_OTHER, 16'h0059, 8'h00, 8'h00);
      chk("ea", 16'h00FF, ea_o);
      chk("target", 16'h005A, target_o);
      chk_len(3'h3, 16'h005C);
      slow <= 1'b0;
   endtask

   task automatic t_indexed;
      go(MODE_IDX_0, 1'b0, 1'b0, OP_OTHER, 16'h0100, 8'hC3, 8'h00);
      chk("ea", 16'h00C3, ea_o);
      chk_len(3'h1, 16'h0101);
      go(MODE_IDX_S, 1'b0, 1'b0, OP_OTHER, 16'h0059, 8'hFF, 8'h00);
      chk("ea", 16'h01FE, ea_o);
      go(MODE_IDX_S, 1'b1, 1'b0, OP_OTHER, 16'h0059, 8'h00, 8'hFF);
      chk("ea", 16'h01FE, ea_o);
      chk_len(3'h3, 16'h005B);
      go(MODE_IDX_L, 1'b0, 1'b0, OP_OTHER, 16'h4000, 8'h10, 8'h00);
      chk("ea", {mv(16'h4001), mv(16'h4002)} + 16'h0010, ea_o);
      chk_len(3'h3, 16'h4003);
   endtask

   task automatic t_indirect;
      logic [7:0] b, p, q;
      b = mv(16'h0501);
      p = mv({8'h00, b});
      q = mv(16'h0502);
      go(MODE_IND_S, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h00, 8'h00);
      chk("ea", {8'h00, mv({8'h00, b})}, ea_o);
      chk_len(3'h3, 16'h0502);
      go(MODE_IND_L, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h00, 8'h00);
      chk("ea", {mv({8'h00, b}), mv({8'h00, b + 8'h01})}, ea_o);
      go(MODE_INDX_S, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'hF0, 8'h00);
      chk("ea", {8'h00, mv({8'h00, b})} + 16'h00F0, ea_o);
      go(MODE_INDX_L, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h10, 8'h00);
      chk("ea", {mv({8'h00, b}), mv({8'h00, b + 8'h01})} + 16'h0010, ea_o);
      go(MODE_BIT_I, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h00, 8'h00);
      chk("ea", {8'h00, p}, ea_o);
      go(MODE_REL_I, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h00, 8'h00);
      chk("target", 16'h0502 + {{8{p[7]}}, p}, target_o);
      go(MODE_BTJ_I, 1'b0, 1'b0, OP_OTHER, 16'h0500, 8'h00, 8'h00);
      chk("ea", {8'h00, p}, ea_o);
      chk("target", 16'h0503 + {{8{q[7]}}, q}, target_o);
      chk_len(3'h4, 16'h0503);
   endtask

   task automatic t_rel_rmw;
      logic [7:0] d;
      d = mv(16'h80D1);
      go(MODE_REL_D, 1'b0, 1'b0, OP_OTHER, 16'h80D0, 8'h00, 8'h00);
      chk("target", 16'h80D2 + {{8{d[7]}}, d}, target_o);
      go(MODE_DIR_L, 1'b0, 1'b1, OP_OTHER, 16'h3000, 8'h00, 8'h00);
      chk("illegal", 16'h0001, {15'h0000, illegal_o});
      go(MODE_DIR_S, 1'b0, 1'b1, OP_OTHER, 16'h0059, 8'h00, 8'h00);
      chk("illegal", 16'h0000, {15'h0000, illegal_o});
      chk("ea", 16'h00FF, ea_o);
      go(MODE_IMM, 1'b0, 1'b1, OP_OTHER, 16'h2000, 8'h00, 8'h00);
      chk("illegal", 16'h0001, {15'h0000, illegal_o});
      go(MODE_COUNT, 1'b0, 1'b0, OP_OTHER, 16'h0600, 8'h00, 8'h00);
      chk("illegal", 16'h0001, {15'h0000, illegal_o});
      chk_len(3'h1, 16'h0601);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      {rst_i, start_i, use_y_i, rmw_i, irq_i, slow} = 6'b100000;
      mode_i   = MODE_INH;
      inh_op_i = OP_OTHER;
      pc_i     = 16'h0000;
      idx_x_i  = 8'h00;
      idx_y_i  = 8'h00;
      n_fail   = 0;
      checks   = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_inherent();
      t_imm_dir();
      t_indexed();
      t_indirect();
      t_rel_rmw();
      report_and_stop();
   end
endmodule // testbench
